// file: core/qsa_arbiter.sv
// quiet slot round robin arbiter of one cluster bus node
// Summary of operation
// - idle holds load-count true, slot counter 1001, down counter long value.
// - down counter is four-bit low section plus fifth bit; low loads node number.
// - in idle the fifth-bit selector supplies constant 1.
// - outside idle with chosen-path carrier, selector takes the wrap-bit flop.
// - entering arbitrate drops load-count; slot and down counters start counting.
// - slot counter runs from 1001, ticks every seven clocks, reloads on tick.
// - 114.28 ns transmit clock gives an 800 ns quiet slot tick.
// - each slot tick decrements the low section by one.
// - carry from zero low with fifth bit 1 clears it, low becomes all ones.
// - carry with fifth bit 0 raises countdown-zero; win flop sets next clock.
// - win, win-ok and move to send only while other path is not busy.
// - chosen-path carrier comes only from the path the mode control picked.
// - chosen-path carrier asserts load-count, restarting all counters.
// - comparator flags below-winner when own number is below interrupted low bits.
// - wrap-bit flop cleared without carrier; set on carrier when below-winner.
// - selector output held in a flop, used after the carrier drops.
// - node 0 beaten by node 15 inhibits wrap-bit setting, short countdown.
// - other-path-busy suppresses win and reloads a count of 16.
// - the 16 comes from forcing fifth bit 0 while low wraps to ones.
// - receive activity on the other path makes other-path-busy true.
// - acknowledge-pending receive state keeps other-path-busy true.
// - either driver on clears delayed-header-timeout, making other-path-busy true.
// - wrap term is 16, node term is own number from zero.
// - maintenance force-arbitration wins without finishing the countdown.
// - after win-ok the chosen path is forced enabled in the receiver.
`timescale 1ns/1ps
`include "qsa_defs.svh"
module qsa_arbiter #(
  parameter int NODE_BITS = `QSA_NODE_BITS,
  parameter int SYNC_STAGES = `QSA_SYNC_STAGES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic SYSTEM_INIT_I,
  input wire logic TRANSMIT_COMMAND_I,
  input wire logic PATH_B_SELECT_I,
  input wire logic FORCE_ARB_I,
  input wire logic SEND_DONE_I,
  input wire logic [NODE_BITS-1:0] NODE_NUMBER_I,
  input wire qsa_pkg::qsa_carrier_t CARRIER_I,
  input wire qsa_pkg::qsa_rx_status_t RX_STATUS_I,
  output logic WIN_O,
  output logic WIN_OK_O,
  output logic LOAD_COUNT_O,
  output logic COUNTDOWN_ZERO_O,
  output logic OTHER_PATH_BUSY_O,
  output logic TX_IDLE_STATE_O,
  output logic TX_ARBITRATE_STATE_O,
  output logic TX_SEND_STATE_O,
  output logic FORCE_PATH_A_O,
  output logic FORCE_PATH_B_O
);

  localparam int SlotCycles = `QSA_SLOT_CYCLES;
  localparam logic [3:0] SlotLast = 4'(`QSA_SLOT_LOAD + SlotCycles - 1);
  localparam int WrapTerm = `QSA_WRAP_TERM;

  generate
    if (NODE_BITS != 4 || WrapTerm != (1 << NODE_BITS)) begin : g_bad_node
      $error("qsa_arbiter: node number must be four bits, wrap term 16");
    end
    if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("qsa_arbiter: only a two-stage carrier synchroniser is built");
    end
    if (SlotCycles < 1 || SlotCycles > 7) begin : g_bad_slot
      $error("qsa_arbiter: slot length must fit the four-bit slot counter");
    end
  endgenerate

  function automatic logic all_ones(input logic [3:0] v);
    all_ones = (v == `QSA_LOW_ONES);
  endfunction

  logic rst_meta_q;
  logic rst_n_q;
  logic [1:0] carrier_sync;
  qsa_pkg::qsa_carrier_t car;
  qsa_pkg::qsa_regs_t s_q;
  qsa_pkg::qsa_regs_t s_d;
  logic [3:0] inverted_node_number;
  logic chosen_carrier;
  logic delayed_header_timeout;
  logic other_path_busy;
  logic load_count;
  logic slot_tick;
  logic low_section_carry;
  logic countdown_zero;
  logic below_winner;
  logic fifth_src;
  logic in_idle;

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!rst_n_q);

  // reset enters asynchronously, released on the clock
  always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  qsa_sync #(
    .WIDTH(2)
  ) u_carrier_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n_q),
    .async_i({CARRIER_I.seen_a, CARRIER_I.seen_b}),
    .sync_o(carrier_sync)
  );

  assign car = '{seen_a: carrier_sync[1], seen_b: carrier_sync[0]};
  assign inverted_node_number = ~NODE_NUMBER_I;
  assign in_idle = (s_q.state == qsa_pkg::QSA_TX_IDLE);

  always_comb begin
    s_d = s_q;
    chosen_carrier = s_q.chosen_path_b ? car.seen_b : car.seen_a;
    delayed_header_timeout = !(RX_STATUS_I.path_a_driver_on || RX_STATUS_I.path_b_driver_on);
    other_path_busy = RX_STATUS_I.rx_in_progress || RX_STATUS_I.ack_pending
                      || !delayed_header_timeout;
    load_count = in_idle || chosen_carrier;
    slot_tick = !load_count && (s_q.slot == SlotLast);
    low_section_carry = slot_tick && (s_q.low == `QSA_LOW_ZERO);
    countdown_zero = low_section_carry && !s_q.fifth && !in_idle;
    below_winner = (NODE_NUMBER_I < s_q.low);
    // fifth-bit source: constant in idle, flop under carrier, held value otherwise
    if (in_idle) begin
      fifth_src = 1'b1;
    end else if (chosen_carrier) begin
      fifth_src = s_q.wrap_bit;
    end else begin
      fifth_src = s_q.wrap_hold;
    end
    s_d.wrap_hold = fifth_src;
    // j-only input: once set it stays until the carrier drops
    if (!chosen_carrier || in_idle) begin
      s_d.wrap_bit = 1'b0;
    end else if (below_winner && !(all_ones(inverted_node_number) && all_ones(s_q.low))) begin
      s_d.wrap_bit = 1'b1;
    end
    if (load_count) begin
      s_d.slot = `QSA_SLOT_LOAD;
      s_d.low = 4'(NODE_NUMBER_I);
      s_d.fifth = fifth_src;
    end else begin
      s_d.slot = slot_tick ? `QSA_SLOT_LOAD : 4'(s_q.slot + 4'h1);
      if (slot_tick) begin
        s_d.low = 4'(s_q.low - 4'h1);
        if (low_section_carry) begin
          s_d.fifth = 1'b0;
        end
      end
    end
    case (s_q.state)
      qsa_pkg::QSA_TX_IDLE: begin
        s_d.win = 1'b0;
        if (TRANSMIT_COMMAND_I) begin
          s_d.state = qsa_pkg::QSA_TX_ARBITRATE;
          s_d.chosen_path_b = PATH_B_SELECT_I;
        end
      end
      qsa_pkg::QSA_TX_ARBITRATE: begin
        // busy check before the win; otherwise the ack could not be received
        if ((countdown_zero || FORCE_ARB_I) && !other_path_busy) begin
          s_d.win = 1'b1;
          s_d.state = qsa_pkg::QSA_TX_SEND;
        end
      end
      qsa_pkg::QSA_TX_SEND: begin
        if (SEND_DONE_I) begin
          s_d.state = qsa_pkg::QSA_TX_IDLE;
          s_d.win = 1'b0;
        end
      end
      default: begin
        s_d.state = qsa_pkg::QSA_TX_IDLE;
      end
    endcase
    if (SYSTEM_INIT_I) begin
      s_d.state = qsa_pkg::QSA_TX_IDLE;
      s_d.win = 1'b0;
      s_d.wrap_bit = 1'b0;
      s_d.wrap_hold = 1'b0;
    end
    // status outputs are one clock behind their causes
    s_d.load_count = load_count;
    s_d.other_busy = other_path_busy;
    s_d.count_zero = countdown_zero;
    s_d.idle_flag = (s_d.state == qsa_pkg::QSA_TX_IDLE);
    s_d.arb_flag = (s_d.state == qsa_pkg::QSA_TX_ARBITRATE);
    s_d.send_flag = (s_d.state == qsa_pkg::QSA_TX_SEND);
    s_d.force_path_a = s_d.win && !s_d.chosen_path_b;
    s_d.force_path_b = s_d.win && s_d.chosen_path_b;
  end

  always_ff @(posedge CLOCK_I or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q <= '{state: qsa_pkg::QSA_TX_IDLE, slot: `QSA_SLOT_LOAD, fifth: 1'b1, load_count: 1'b1,
               idle_flag: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign WIN_O = s_q.win;
  assign WIN_OK_O = s_q.win;
  assign LOAD_COUNT_O = s_q.load_count;
  assign COUNTDOWN_ZERO_O = s_q.count_zero;
  assign OTHER_PATH_BUSY_O = s_q.other_busy;
  assign TX_IDLE_STATE_O = s_q.idle_flag;
  assign TX_ARBITRATE_STATE_O = s_q.arb_flag;
  assign TX_SEND_STATE_O = s_q.send_flag;
  assign FORCE_PATH_A_O = s_q.force_path_a;
  assign FORCE_PATH_B_O = s_q.force_path_b;

  sequence slot_started;
    slot_tick && (s_q.state == qsa_pkg::QSA_TX_ARBITRATE) && !SYSTEM_INIT_I;
  endsequence

  sequence quiet_run;
    (!chosen_carrier && (s_q.state == qsa_pkg::QSA_TX_ARBITRATE) && !SYSTEM_INIT_I)[*7];
  endsequence

  a_idle_preload: assert property (in_idle && !SYSTEM_INIT_I |=> (s_q.slot == `QSA_SLOT_LOAD)
    && (s_q.low == $past(NODE_NUMBER_I)) && s_q.fifth && s_q.load_count)
    else $error("idle did not preload the counters");

  a_slot_period: assert property (slot_started ##1 quiet_run |-> slot_tick)
    else $error("slot tick period is not seven clocks");

  a_low_decrement: assert property (slot_tick && !low_section_carry
    |=> s_q.low == 4'($past(s_q.low) - 4'h1))
    else $error("low section did not step down on slot tick");

  a_fifth_wrap: assert property (low_section_carry && s_q.fifth |=> !s_q.fifth && all_ones(s_q.low))
    else $error("carry with fifth bit set did not wrap");

  a_win_follow: assert property (countdown_zero && !other_path_busy && !SYSTEM_INIT_I
    && (s_q.state == qsa_pkg::QSA_TX_ARBITRATE) |=> WIN_O && (s_q.state == qsa_pkg::QSA_TX_SEND))
    else $error("countdown zero did not produce a win");

  a_busy_holds: assert property (countdown_zero && other_path_busy && !FORCE_ARB_I
    |=> !WIN_O && !s_q.fifth && all_ones(s_q.low))
    else $error("busy other path did not reload sixteen");

  a_carrier_reload: assert property (chosen_carrier && !SYSTEM_INIT_I
    && (s_q.state == qsa_pkg::QSA_TX_ARBITRATE) |=> (s_q.slot == `QSA_SLOT_LOAD)
    && (s_q.low == $past(NODE_NUMBER_I)))
    else $error("carrier did not restart the countdown");

  a_wrap_clear: assert property (!chosen_carrier |=> !s_q.wrap_bit)
    else $error("wrap bit not held clear without carrier");

  a_node0_inhibit: assert property (chosen_carrier && (NODE_NUMBER_I == 4'h0) && all_ones(s_q.low)
    && !s_q.wrap_bit |=> !s_q.wrap_bit)
    else $error("node zero took the long countdown after node fifteen");

  a_force_path: assert property (WIN_O |-> (FORCE_PATH_A_O != FORCE_PATH_B_O)
    && (FORCE_PATH_B_O == s_q.chosen_path_b))
    else $error("win did not force the chosen receive path");

  a_init_idle: assert property (SYSTEM_INIT_I |=> TX_IDLE_STATE_O && !s_q.wrap_bit && !s_q.wrap_hold ##1
    LOAD_COUNT_O)
    else $error("system init did not return to idle");

endmodule // qsa_arbiter

// file: common/qsa_defs.svh
// timing counts, load values and field constants of the quiet slot arbiter
`ifndef QSA_DEFS_SVH
`define QSA_DEFS_SVH

`define QSA_XMIT_PERIOD_PS 114280
`define QSA_SLOT_PS 800000
`define QSA_SLOT_CYCLES (`QSA_SLOT_PS / `QSA_XMIT_PERIOD_PS)
`define QSA_SLOT_LOAD 4'h9
`define QSA_NODE_BITS 4
`define QSA_WRAP_TERM 16
`define QSA_SYNC_STAGES 2
`define QSA_LOW_ZERO 4'h0
`define QSA_LOW_ONES 4'hF

`endif

// file: common/qsa_pkg.sv
// types shared by the quiet slot arbiter files
package qsa_pkg;

  typedef enum logic [1:0] {
    QSA_TX_IDLE,
    QSA_TX_ARBITRATE,
    QSA_TX_SEND
  } qsa_tx_state_t;

  typedef struct packed {
    logic seen_a;
    logic seen_b;
  } qsa_carrier_t;

  typedef struct packed {
    logic rx_in_progress;
    logic ack_pending;
    logic path_a_driver_on;
    logic path_b_driver_on;
  } qsa_rx_status_t;

  typedef struct packed {
    qsa_tx_state_t state;
    logic chosen_path_b;
    logic [3:0] slot;
    logic [3:0] low;
    logic fifth;
    logic wrap_bit;
    logic wrap_hold;
    logic win;
    logic load_count;
    logic other_busy;
    logic count_zero;
    logic idle_flag;
    logic arb_flag;
    logic send_flag;
    logic force_path_a;
    logic force_path_b;
  } qsa_regs_t;

endpackage

// file: core/qsa_sync.sv
// two-stage synchroniser for carrier detector levels
`timescale 1ns/1ps
module qsa_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("qsa_sync: WIDTH must be at least 1");
    end
  endgenerate

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // qsa_sync

// file: tb/qsa_peer_node.sv
// partner model: a winning node whose frame shows as carrier on one path
`timescale 1ns/1ps
module qsa_peer_node (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [15:0] at_i,
  input wire logic [15:0] len_i,
  input wire logic path_b_i,
  output qsa_pkg::qsa_carrier_t carrier_o
);
  int cnt = -1;
  logic on;
  // no carrier outside the frame; detectors read quiet bus as low
  assign on = at_i != 16'h0000 && cnt >= int'(at_i) && cnt < int'(at_i) + int'(len_i);
  always @(posedge clk_i) begin
    cnt <= start_i ? 0 : cnt + 1;
    carrier_o <= {on & ~path_b_i, on & path_b_i};
  end
endmodule // qsa_peer_node

// file: tb/qsa_arbiter_tb.sv
// self-checking bench of the quiet slot arbiter with a model of slot counts
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %0d seen %0d", nm, e, g); end end
module qsa_arbiter_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic init_q = 1'b0, cmd_q = 1'b0, pb_q = 1'b0, force_q = 1'b0, done_q = 1'b0;
  logic start_q = 1'b0, other_q = 1'b0;
  logic [3:0] node_q = 4'h0;
  logic [15:0] at_q = 16'h0000;
  qsa_pkg::qsa_rx_status_t rx_q = '0;
  qsa_pkg::qsa_carrier_t car;
  logic win, win_ok, load, zero, busy, idle, arb, send, fpa, fpb;
  int bad_count = 0, n_compared = 0, cyc = 0, seed = 98746;
  int tn[11] = '{0, 15, 0, 5, 5, 5, 0, 0, 0, 0, 0};
  int tk[11] = '{0, 0, 0, 19, 10, 10, 1, 0, 0, 0, 0};
  int tb[11] = '{-1, -1, -1, -1, -1, -1, -1, 0, 1, 2, 3};
  always #5 clk = ~clk;
  qsa_arbiter i_dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .SYSTEM_INIT_I(init_q), .TRANSMIT_COMMAND_I(cmd_q),
    .PATH_B_SELECT_I(pb_q), .FORCE_ARB_I(force_q), .SEND_DONE_I(done_q), .NODE_NUMBER_I(node_q),
    .CARRIER_I(car), .RX_STATUS_I(rx_q), .WIN_O(win), .WIN_OK_O(win_ok), .LOAD_COUNT_O(load),
    .COUNTDOWN_ZERO_O(zero), .OTHER_PATH_BUSY_O(busy), .TX_IDLE_STATE_O(idle),
    .TX_ARBITRATE_STATE_O(arb), .TX_SEND_STATE_O(send), .FORCE_PATH_A_O(fpa), .FORCE_PATH_B_O(fpb));
  qsa_peer_node i_peer (.clk_i(clk), .start_i(start_q), .at_i(at_q), .len_i(16'h0014),
    .path_b_i(pb_q ^ other_q), .carrier_o(car));
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ceiling well above the ~2200 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  // expected slot ticks; carrier k ticks into a start from 16+n
  function automatic int exp_ticks(int n, int k, logic oth, int bb);
    int low;
    if (bb >= 0) return 33;
    if (k == 0 || oth) return 17 + n;
    low = (48 + n - k) % 16;
    if (n < low && !(n == 0 && low == 15)) return 17 + n;
    return n + 1;
  endfunction
  task chk_idle;
    @(negedge clk);
    `CHK("idle", 1'b1, idle)
    `CHK("load", 1'b1, load)
    `CHK("win", 1'b0, win)
  endtask
  task cmd(input int n, input logic p);
    @(posedge clk);
    node_q <= n[3:0];
    pb_q <= p;
    cmd_q <= 1'b1;
    @(posedge clk);
    cmd_q <= 1'b0;
  endtask
  task end_send;
    @(posedge clk);
    done_q <= 1'b1;
    @(posedge clk);
    done_q <= 1'b0;
    repeat (3) @(posedge clk);
    chk_idle();
  endtask
  task run(input int n, input int k, input logic oth, input int bb);
    int t0, tr, w;
    @(posedge clk);
    rx_q <= (bb >= 0) ? 4'h8 >> bb : 4'h0;
    // mid-slot arrival: exactly k ticks taken before the synchronised carrier lands
    at_q <= k ? 16'(7 * k - 1) : 16'h0000;
    other_q <= oth;
    cmd(n, 1'($random(seed)));
    t0 = cyc;
    start_q <= 1'b1;
    tr = (k != 0 && !oth) ? t0 + 7 * k + 23 : t0;
    w = 0;
    while (win !== 1'b1 && w < 400) begin
      @(posedge clk);
      start_q <= 1'b0;
      if (w == 150) rx_q <= '0;
      @(negedge clk);
      w++;
      if (w == 5) `CHK("busy", bb >= 0, busy)
      if (w == 5) `CHK("arbitrate", 1'b1, arb)
      if (w == 5) `CHK("load", 1'b0, load)
    end
    `CHK("zero", 1'b1, zero)
    `CHK("ticks", exp_ticks(n, k, oth, bb), (cyc - tr) / 7)
    `CHK("win_ok", 1'b1, win_ok)
    `CHK("send", 1'b1, send)
    `CHK("force_b", pb_q, fpb)
    `CHK("force_a", ~pb_q, fpa)
    end_send();
  endtask
  initial begin
    tn[2] = 1 + ($unsigned($random(seed)) % 14);
    repeat (16) @(posedge clk);
    chk_idle();
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      run(tn[i], tk[i], i == 5, tb[i]);
      $display("test %0d done", i);
    end
    cmd(3, 1'b0);
    repeat (10) @(posedge clk);
    force_q <= 1'b1;
    repeat (4) @(posedge clk);
    force_q <= 1'b0;
    @(negedge clk);
    `CHK("forced win", 1'b1, win)
    end_send();
    $display("test force done");
    cmd(3, 1'b1);
    repeat (10) @(posedge clk);
    init_q <= 1'b1;
    @(posedge clk);
    init_q <= 1'b0;
    repeat (2) @(posedge clk);
    chk_idle();
    $display("test init done");
    wrap_up();
  end
endmodule // qsa_arbiter_tb
